// file: include/icd_defines.svh
`ifndef ICD_DEFINES_SVH
`define ICD_DEFINES_SVH

// ==================================================================
// widths
`define ICD_LEN_W 2
`define ICD_CNT_W 4
`define ICD_CLS_W 4

// ==================================================================
// instruction byte lengths
`define ICD_LEN_1 2'd1
`define ICD_LEN_2 2'd2
`define ICD_LEN_3 2'd3

// ==================================================================
// base clock counts (branch not taken)
`define ICD_CLK_1 4'h1
`define ICD_CLK_2 4'h2
`define ICD_CLK_3 4'h3
`define ICD_CLK_4 4'h4
`define ICD_CLK_5 4'h5
`define ICD_CLK_8 4'h8

// ==================================================================
// sequencer counts
`define ICD_CNT_LAST 4'h1
`define ICD_CNT_SAMPLE 4'h2
`define ICD_CNT_ZERO 4'h0

// ==================================================================
// opcodes with a fixed meaning
`define ICD_OP_NOP 8'h00
`define ICD_OP_SPARE 8'ha5

`endif

// file: include/icd_pkg.sv
`default_nettype none

package icd_pkg;

  // ================================================================
  // instruction groups reported to the datapath
  typedef enum logic [3:0] {
    ICD_CLS_NOP = 4'h0,
    ICD_CLS_ALU = 4'h1,
    ICD_CLS_MOVE = 4'h2,
    ICD_CLS_BIT = 4'h3,
    ICD_CLS_MUL = 4'h4,
    ICD_CLS_DIV = 4'h5,
    ICD_CLS_CODE = 4'h6,
    ICD_CLS_XDATA = 4'h7,
    ICD_CLS_STACK = 4'h8,
    ICD_CLS_BRANCH = 4'h9,
    ICD_CLS_JUMP = 4'ha,
    ICD_CLS_CALL = 4'hb,
    ICD_CLS_RET = 4'hc,
    ICD_CLS_NIBBLE = 4'hd
  } icd_class_e;

  // ================================================================
  // decoded view of one opcode
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] clocks;
    icd_class_e cls;
    logic cond;
  } icd_decode_s;

  // ================================================================
  // sequencer states
  typedef enum logic [0:0] {
    ICD_ST_IDLE = 1'b0,
    ICD_ST_EXEC = 1'b1
  } icd_state_e;

endpackage

`default_nettype wire

// file: hdl/icd_cycle_counter.sv
`include "icd_defines.svh"
`default_nettype none

module icd_cycle_counter #(
  parameter int CNT_W = `ICD_CNT_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic hold,
  output logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] count_next
);

  // ================================================================
  // elaboration check
  if (CNT_W < 4) begin : g_bad_width
    $error("counter too narrow for the longest instruction");
  end

  logic [CNT_W-1:0] count_reg;

  // ================================================================
  // down-counter in whole core clocks
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (hold) begin
      count_next = count_reg;
    end else if (count_reg != '0) begin
      count_next = count_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule

`default_nettype wire

// file: hdl/icd_rel_target.sv
`default_nettype none

module icd_rel_target #(
  parameter int PC_W = 16
) (
  input wire logic [PC_W-1:0] op_pc,
  input wire logic [1:0] len,
  input wire logic [7:0] rel,
  output logic [PC_W-1:0] next_pc,
  output logic [PC_W-1:0] target
);

  // ================================================================
  // elaboration check
  if (PC_W < 8) begin : g_bad_width
    $error("program counter narrower than a displacement");
  end

  // ================================================================
  // signed offset from the byte after the instruction
  always_comb begin
    next_pc = op_pc + PC_W'(len);
    target = next_pc + PC_W'({{(PC_W-8){rel[7]}}, rel});
  end

endmodule

`default_nettype wire

// file: hdl/icd_core_timing.sv
// Summary of operation
// - opcodes, addressing and flag effects follow the standard 8-bit instruction set.
// - all latencies are whole core clocks; no machine-cycle unit exists.
// - conditional branch not taken ends one clock sooner than taken.
// - accumulator with bank register ops, inc and dec: one byte, one clock.
// - accumulator with direct byte and direct inc/dec: two bytes, two clocks.
// - accumulator with indirect pointer forms: one byte, two clocks.
// - immediate into accumulator: two bytes, two clocks.
// - logic op of immediate into direct byte: three bytes, three clocks.
// - logic op of accumulator into direct byte: two bytes, two clocks.
// - multiply accumulator by b takes four clocks.
// - divide accumulator by b takes eight clocks, the longest.
// - single-byte ops on the accumulator alone complete in one clock.
// - direct-to-direct and immediate-to-direct moves: three bytes, three clocks.
// - data pointer load with 16-bit constant: three bytes, three clocks.
// - code byte reads indexed by accumulator take one byte, three clocks.
// - external data moves, either pointer form, take one byte, three clocks.
// - stack push and pop of a direct byte: two bytes, two clocks.
// - low nibble exchange with indirect memory: one byte, two clocks.
// - immediate to indirect two bytes; accumulator to indirect one byte; both two clocks.
// - relative displacement is signed, added to the next instruction address.
// - the spare opcode behaves exactly as the no-operation.
`include "icd_defines.svh"
`default_nettype none

module icd_core_timing #(
  parameter int PC_W = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic [PC_W-1:0] op_pc,
  input wire logic [7:0] op_rel,
  input wire logic branch_cond,
  output logic op_ready,
  output logic exec_busy,
  output logic instr_done,
  output logic [1:0] instr_len,
  output logic [3:0] instr_clocks,
  output icd_pkg::icd_class_e instr_class,
  output logic instr_cond,
  output logic branch_taken,
  output logic [PC_W-1:0] next_pc,
  output logic [PC_W-1:0] branch_target
);
  import icd_pkg::*;

  // ================================================================
  // elaboration check
  if (PC_W < 8 || PC_W > 16) begin : g_bad_pc
    $error("program counter width out of range");
  end

  // ================================================================
  // decode helpers
  function automatic icd_decode_s icd_mk(input logic [1:0] len, input logic [3:0] clk,
                                         input icd_class_e cls, input logic cond);
    icd_decode_s d;
    d.len = len;
    d.clocks = clk;
    d.cls = cls;
    d.cond = cond;
    return d;
  endfunction

  // base clocks are the not-taken figures; taken adds one at run time
  function automatic icd_decode_s icd_decode(input logic [7:0] op);
    icd_decode_s d;
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_NOP, 1'b0);
    if (lo[3]) begin
      unique case (hi)
        4'h7: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
        4'h8: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
        4'ha: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
        4'hb: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_BRANCH, 1'b1);
        4'hd: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_BRANCH, 1'b1);
        4'hc, 4'he, 4'hf: d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_MOVE, 1'b0);
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9: begin
          d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_ALU, 1'b0);
        end
      endcase
    end else if (lo[3:1] == 3'b011) begin
      unique case (hi)
        4'h7: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
        4'h8: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
        4'ha: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
        4'hb: d = icd_mk(`ICD_LEN_3, `ICD_CLK_4, ICD_CLS_BRANCH, 1'b1);
        4'hd: d = icd_mk(`ICD_LEN_1, `ICD_CLK_2, ICD_CLS_NIBBLE, 1'b0);
        4'hc, 4'he, 4'hf: d = icd_mk(`ICD_LEN_1, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9: begin
          d = icd_mk(`ICD_LEN_1, `ICD_CLK_2, ICD_CLS_ALU, 1'b0);
        end
      endcase
    end else begin
      unique case (lo)
        4'h5: begin
          unique case (hi)
            4'h7: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_MOVE, 1'b0);
            4'h8: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_MOVE, 1'b0);
            4'ha: d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_NOP, 1'b0);
            4'hb: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_BRANCH, 1'b1);
            4'hc: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
            4'hd: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_BRANCH, 1'b1);
            4'he, 4'hf: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9: begin
              d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_ALU, 1'b0);
            end
          endcase
        end
        4'h4: begin
          unique case (hi)
            4'h0, 4'h1: d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_ALU, 1'b0);
            4'h7: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_MOVE, 1'b0);
            4'h8: d = icd_mk(`ICD_LEN_1, `ICD_CLK_8, ICD_CLS_DIV, 1'b0);
            4'ha: d = icd_mk(`ICD_LEN_1, `ICD_CLK_4, ICD_CLS_MUL, 1'b0);
            4'hb: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_BRANCH, 1'b1);
            4'hc, 4'hd, 4'he, 4'hf: begin
              d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_ALU, 1'b0);
            end
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9: begin
              d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_ALU, 1'b0);
            end
          endcase
        end
        4'h3: begin
          unique case (hi)
            4'h0, 4'h1, 4'h2, 4'h3: d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_ALU, 1'b0);
            4'h4, 4'h5, 4'h6: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_ALU, 1'b0);
            4'h7: d = icd_mk(`ICD_LEN_1, `ICD_CLK_3, ICD_CLS_JUMP, 1'b0);
            4'h8, 4'h9: d = icd_mk(`ICD_LEN_1, `ICD_CLK_3, ICD_CLS_CODE, 1'b0);
            4'ha: d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_ALU, 1'b0);
            4'hb, 4'hc, 4'hd: d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_BIT, 1'b0);
            4'he, 4'hf: d = icd_mk(`ICD_LEN_1, `ICD_CLK_3, ICD_CLS_XDATA, 1'b0);
          endcase
        end
        4'h2: begin
          unique case (hi)
            4'h0: d = icd_mk(`ICD_LEN_3, `ICD_CLK_4, ICD_CLS_JUMP, 1'b0);
            4'h1: d = icd_mk(`ICD_LEN_3, `ICD_CLK_4, ICD_CLS_CALL, 1'b0);
            4'h2, 4'h3: d = icd_mk(`ICD_LEN_1, `ICD_CLK_5, ICD_CLS_RET, 1'b0);
            4'h4, 4'h5, 4'h6: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_ALU, 1'b0);
            4'he, 4'hf: d = icd_mk(`ICD_LEN_1, `ICD_CLK_3, ICD_CLS_XDATA, 1'b0);
            4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd: begin
              d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_BIT, 1'b0);
            end
          endcase
        end
        4'h1: begin
          if (hi[0]) begin
            d = icd_mk(`ICD_LEN_2, `ICD_CLK_3, ICD_CLS_CALL, 1'b0);
          end else begin
            d = icd_mk(`ICD_LEN_2, `ICD_CLK_3, ICD_CLS_JUMP, 1'b0);
          end
        end
        4'h0: begin
          unique case (hi)
            4'h0: d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_NOP, 1'b0);
            4'h1, 4'h2, 4'h3: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_BRANCH, 1'b1);
            4'h4, 4'h5, 4'h6, 4'h7: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_BRANCH, 1'b1);
            4'h8: d = icd_mk(`ICD_LEN_2, `ICD_CLK_3, ICD_CLS_JUMP, 1'b0);
            4'h9: d = icd_mk(`ICD_LEN_3, `ICD_CLK_3, ICD_CLS_MOVE, 1'b0);
            4'ha, 4'hb: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_BIT, 1'b0);
            4'hc, 4'hd: d = icd_mk(`ICD_LEN_2, `ICD_CLK_2, ICD_CLS_STACK, 1'b0);
            4'he, 4'hf: d = icd_mk(`ICD_LEN_1, `ICD_CLK_3, ICD_CLS_XDATA, 1'b0);
          endcase
        end
        default: d = icd_mk(`ICD_LEN_1, `ICD_CLK_1, ICD_CLS_NOP, 1'b0);
      endcase
    end
    return d;
  endfunction

  // ================================================================
  // state
  icd_state_e state_reg, state_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic sampled_reg, sampled_next;
  logic taken_reg, taken_next;
  logic [1:0] len_reg, len_next;
  logic [3:0] clocks_reg, clocks_next;
  icd_class_e cls_reg, cls_next;
  logic cond_reg, cond_next;
  logic [PC_W-1:0] npc_reg, npc_next;
  logic [PC_W-1:0] target_reg, target_next;

  icd_decode_s dec;
  logic accept;
  logic cnt_load;
  logic cnt_hold;
  logic [3:0] cnt;
  logic [3:0] cnt_next;
  logic [PC_W-1:0] calc_npc;
  logic [PC_W-1:0] calc_target;

  assign dec = icd_decode(op_byte);
  assign accept = op_valid && ready_reg;

  // ================================================================
  // datapath helpers
  icd_rel_target #(
    .PC_W(PC_W)
  ) u_rel (
    .op_pc(op_pc),
    .len(dec.len),
    .rel(op_rel),
    .next_pc(calc_npc),
    .target(calc_target)
  );

  icd_cycle_counter #(
    .CNT_W(`ICD_CNT_W)
  ) u_cnt (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(cnt_load),
    .load_value(dec.clocks),
    .hold(cnt_hold),
    .count(cnt),
    .count_next(cnt_next)
  );

  // ================================================================
  // sequencer
  // the condition is sampled one clock before the base end so that
  // ready can still come straight from a flop on the last clock
  always_comb begin
    state_next = state_reg;
    sampled_next = sampled_reg;
    taken_next = taken_reg;
    len_next = len_reg;
    clocks_next = clocks_reg;
    cls_next = cls_reg;
    cond_next = cond_reg;
    npc_next = npc_reg;
    target_next = target_reg;
    cnt_load = 1'b0;
    cnt_hold = 1'b0;
    if (accept) begin
      state_next = ICD_ST_EXEC;
      cnt_load = 1'b1;
      sampled_next = 1'b0;
      taken_next = 1'b0;
      len_next = dec.len;
      clocks_next = dec.clocks;
      cls_next = dec.cls;
      cond_next = dec.cond;
      npc_next = calc_npc;
      target_next = calc_target;
    end else if (state_reg == ICD_ST_EXEC) begin
      if (cnt == `ICD_CNT_LAST) begin
        state_next = ICD_ST_IDLE;
      end else if (cond_reg && !sampled_reg && cnt == `ICD_CNT_SAMPLE) begin
        sampled_next = 1'b1;
        taken_next = branch_cond;
        cnt_hold = branch_cond;
        clocks_next = branch_cond ? clocks_reg + 4'h1 : clocks_reg;
      end
    end
    ready_next = (state_next == ICD_ST_IDLE) || (cnt_next == `ICD_CNT_LAST);
    done_next = (state_next == ICD_ST_EXEC) && (cnt_next == `ICD_CNT_LAST);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ICD_ST_IDLE;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      sampled_reg <= 1'b0;
      taken_reg <= 1'b0;
      len_reg <= `ICD_LEN_1;
      clocks_reg <= `ICD_CLK_1;
      cls_reg <= ICD_CLS_NOP;
      cond_reg <= 1'b0;
      npc_reg <= '0;
      target_reg <= '0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      sampled_reg <= sampled_next;
      taken_reg <= taken_next;
      len_reg <= len_next;
      clocks_reg <= clocks_next;
      cls_reg <= cls_next;
      cond_reg <= cond_next;
      npc_reg <= npc_next;
      target_reg <= target_next;
    end
  end

  // ================================================================
  // outputs
  assign op_ready = ready_reg;
  assign exec_busy = (state_reg == ICD_ST_EXEC);
  assign instr_done = done_reg;
  assign instr_len = len_reg;
  assign instr_clocks = clocks_reg;
  assign instr_class = cls_reg;
  assign instr_cond = cond_reg;
  assign branch_taken = taken_reg;
  assign next_pc = npc_reg;
  assign branch_target = target_reg;

endmodule

`default_nettype wire

// file: testbench/icd_core_timing_asserts.sv
`default_nettype none
// ==========================================
// timing checker on the decoder ports
module icd_timing_asserts
  import icd_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic [PC_W-1:0] op_pc,
  input wire logic [7:0] op_rel,
  input wire logic branch_cond,
  input wire logic op_ready,
  input wire logic exec_busy,
  input wire logic instr_done,
  input wire logic [1:0] instr_len,
  input wire logic [3:0] instr_clocks,
  input wire icd_pkg::icd_class_e instr_class,
  input wire logic branch_taken,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic [PC_W-1:0] branch_target
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic acc;
  logic [PC_W-1:0] rel_ext;
  assign acc = op_valid && op_ready;
  // offset is signed, so widen with its top bit
  assign rel_ext = {{(PC_W-8){op_rel[7]}}, op_rel};
  sequence s_done_after3;
    !instr_done[*3] ##1 instr_done;
  endsequence
  sequence s_done_after7;
    !instr_done[*7] ##1 instr_done;
  endsequence
  idle_after_reset_a: assert property ($fell(srst) |-> op_ready && !exec_busy && !instr_done)
    else $error("core not idle after reset");
  refuse_busy_a: assert property (exec_busy && !instr_done |-> !op_ready)
    else $error("ready raised mid instruction");
  done_pulse_a: assert property (instr_done && !op_valid |=> !instr_done)
    else $error("done longer than one clock");
  one_clock_a: assert property (acc && op_byte == 8'h28 |=> instr_done && instr_len == 2'd1)
    else $error("register add not one clock");
  dir_logic_a: assert property (acc && op_byte == 8'h53 |=>
    instr_len == 2'd3 && !instr_done ##1 !instr_done ##1 instr_done)
    else $error("logic to direct not three clocks");
  mul_four_a: assert property (acc && op_byte == 8'ha4 |=> s_done_after3)
    else $error("multiply not four clocks");
  div_eight_a: assert property (acc && op_byte == 8'h84 |=> s_done_after7)
    else $error("divide not eight clocks");
  spare_nop_a: assert property (acc && op_byte == 8'ha5 |=>
    instr_done && instr_class == ICD_CLS_NOP)
    else $error("spare opcode not a no-op");
  not_taken_a: assert property (acc && op_byte == 8'h40 ##1 !branch_cond |=>
    instr_done && !branch_taken)
    else $error("untaken branch not at base");
  taken_extra_a: assert property (acc && op_byte == 8'h40 ##1 branch_cond |=>
    !instr_done && branch_taken ##1 instr_done && instr_clocks == 4'h3)
    else $error("taken branch not one extra clock");
  rel_target_a: assert property (acc && op_byte == 8'h40 |=>
    next_pc == $past(op_pc) + 2'd2 && branch_target == next_pc + $past(rel_ext))
    else $error("branch target wrong");
endmodule
bind icd_core_timing icd_timing_asserts #(.PC_W(PC_W)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .op_valid(op_valid), .op_byte(op_byte),
  .op_pc(op_pc), .op_rel(op_rel), .branch_cond(branch_cond), .op_ready(op_ready),
  .exec_busy(exec_busy), .instr_done(instr_done), .instr_len(instr_len),
  .instr_clocks(instr_clocks), .instr_class(instr_class), .branch_taken(branch_taken),
  .next_pc(next_pc), .branch_target(branch_target));
`default_nettype wire

// file: testbench/icd_code_rom.sv
`default_nettype none
// ==========================================
// program memory pattern model
module icd_code_rom (
  input wire logic [15:0] addr,
  output logic [7:0] code_byte,
  output logic [7:0] rel_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // opcode is the low address byte and the offset the inverted high byte,
  // so one address picks both the opcode and the offset sign
  assign code_byte = addr[7:0];
  assign rel_byte = ~addr[15:8];
endmodule
`default_nettype wire

// file: testbench/icd_core_timing_bench.sv
`default_nettype none
module icd_core_timing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import icd_pkg::*;
  logic ref_clk, srst, op_valid, branch_cond;
  logic op_ready, exec_busy, instr_done, instr_cond, branch_taken;
  logic [7:0] op_byte, op_rel;
  logic [15:0] op_pc, next_pc, branch_target;
  logic [1:0] instr_len;
  logic [3:0] instr_clocks;
  icd_class_e instr_class;
  int err_total, compares;
  icd_code_rom u_rom (.addr(op_pc), .code_byte(op_byte), .rel_byte(op_rel));
  icd_core_timing #(.PC_W(16)) DUT (
    .ref_clk(ref_clk), .srst(srst), .op_valid(op_valid), .op_byte(op_byte),
    .op_pc(op_pc), .op_rel(op_rel), .branch_cond(branch_cond), .op_ready(op_ready),
    .exec_busy(exec_busy), .instr_done(instr_done), .instr_len(instr_len),
    .instr_clocks(instr_clocks), .instr_class(instr_class), .instr_cond(instr_cond),
    .branch_taken(branch_taken), .next_pc(next_pc), .branch_target(branch_target));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================
  // checking and closing
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_idle();
    cmp("op_ready", 16'h1, {15'h0, op_ready});
    cmp("exec_busy", 16'h0, {15'h0, exec_busy});
    cmp("instr_done", 16'h0, {15'h0, instr_done});
    cmp("instr_len", 16'h1, {14'h0, instr_len});
    cmp("instr_clocks", 16'h1, {12'h0, instr_clocks});
    cmp("instr_class", {12'h0, ICD_CLS_NOP}, {12'h0, instr_class});
    cmp("instr_cond", 16'h0, {15'h0, instr_cond});
    cmp("branch_taken", 16'h0, {15'h0, branch_taken});
    cmp("next_pc", 16'h0, next_pc);
    cmp("branch_target", 16'h0, branch_target);
  endtask
  // ==========================================
  // one instruction; a refused opcode is offered while it runs
  task automatic run_op(input logic [15:0] pc, input logic cnd, input logic [1:0] len,
      input logic [3:0] clk);
    int n;
    n = 0;
    @(negedge ref_clk);
    op_pc = pc;
    branch_cond = cnd;
    op_valid = 1'b1;
    do begin
      @(negedge ref_clk);
      n++;
      if (instr_done !== 1'b1) begin
        op_pc = 16'h0085;
        cmp("op_ready", 16'h0, {15'h0, op_ready});
      end
    end while (instr_done !== 1'b1 && n < 12);
    op_valid = 1'b0;
    if (n >= 12) begin
      err_total++;
      print_verdict();
    end
    cmp("cycles", {12'h0, clk}, 16'(n));
    cmp("op_ready", 16'h1, {15'h0, op_ready});
    cmp("exec_busy", 16'h1, {15'h0, exec_busy});
    cmp("instr_clocks", {12'h0, clk}, {12'h0, instr_clocks});
    cmp("instr_len", {14'h0, len}, {14'h0, instr_len});
    cmp("next_pc", pc + {14'h0, len}, next_pc);
  endtask
  task automatic branch(input logic [15:0] pc, input logic cnd, input logic [1:0] len,
      input logic [3:0] base);
    logic [7:0] rel;
    rel = ~pc[15:8];
    run_op(pc, cnd, len, base + {3'h0, cnd});
    cmp("instr_cond", 16'h1, {15'h0, instr_cond});
    cmp("branch_taken", {15'h0, cnd}, {15'h0, branch_taken});
    cmp("branch_target", pc + {14'h0, len} + {{8{rel[7]}}, rel}, branch_target);
  endtask
  task automatic mid_reset();
    @(negedge ref_clk);
    op_pc = 16'h0084;
    op_valid = 1'b1;
    repeat (3) @(negedge ref_clk);
    op_valid = 1'b0;
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check_idle();
    srst = 1'b0;
  endtask
  // ==========================================
  // main sequence
  initial begin
    srst = 1'b1;
    op_valid = 1'b0;
    branch_cond = 1'b0;
    op_pc = 16'h0000;
    err_total = 0;
    compares = 0;
    repeat (10) @(negedge ref_clk);
    check_idle();
    srst = 1'b0;
    run_op(16'h0128, 1'b0, 2'd1, 4'h1);
    run_op(16'h00c8, 1'b0, 2'd1, 4'h1);
    run_op(16'h0205, 1'b0, 2'd2, 4'h2);
    run_op(16'h0026, 1'b0, 2'd1, 4'h2);
    run_op(16'h0324, 1'b0, 2'd2, 4'h2);
    run_op(16'h0053, 1'b0, 2'd3, 4'h3);
    run_op(16'h0052, 1'b0, 2'd2, 4'h2);
    run_op(16'h00a4, 1'b0, 2'd1, 4'h4);
    cmp("instr_class", {12'h0, ICD_CLS_MUL}, {12'h0, instr_class});
    run_op(16'h0084, 1'b0, 2'd1, 4'h8);
    cmp("instr_class", {12'h0, ICD_CLS_DIV}, {12'h0, instr_class});
    run_op(16'h00d4, 1'b0, 2'd1, 4'h1);
    run_op(16'h0033, 1'b0, 2'd1, 4'h1);
    run_op(16'h0085, 1'b0, 2'd3, 4'h3);
    run_op(16'h0075, 1'b0, 2'd3, 4'h3);
    run_op(16'h0090, 1'b0, 2'd3, 4'h3);
    run_op(16'h0093, 1'b0, 2'd1, 4'h3);
    run_op(16'h0083, 1'b0, 2'd1, 4'h3);
    run_op(16'h00e0, 1'b0, 2'd1, 4'h3);
    run_op(16'h00f2, 1'b0, 2'd1, 4'h3);
    run_op(16'h00c0, 1'b0, 2'd2, 4'h2);
    run_op(16'h00d0, 1'b0, 2'd2, 4'h2);
    run_op(16'h00d6, 1'b0, 2'd1, 4'h2);
    run_op(16'h0076, 1'b0, 2'd2, 4'h2);
    run_op(16'h00f6, 1'b0, 2'd1, 4'h2);
    run_op(16'h00c3, 1'b0, 2'd1, 4'h1);
    run_op(16'h00b2, 1'b0, 2'd2, 4'h2);
    run_op(16'h04a5, 1'b0, 2'd1, 4'h1);
    cmp("instr_class", {12'h0, ICD_CLS_NOP}, {12'h0, instr_class});
    branch(16'h1040, 1'b0, 2'd2, 4'h2);
    branch(16'h1040, 1'b1, 2'd2, 4'h2);
    branch(16'hf020, 1'b1, 2'd3, 4'h3);
    mid_reset();
    run_op(16'h0128, 1'b0, 2'd1, 4'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
